// ===== self_program_control.sv
// Purpose: control register and sequencing for CPU self-programming of flash
// Assumes: CPU strobes are on mclk; spm_exec/lpm_exec are one-cycle pulses
// Notes:   boot sections and lock protection modes are not modelled
`timescale 1ns/1ns
module self_program_control
   import spm_pkg::*;
#(
   parameter int WORD_AW     = 5,
   parameter int PAGE_AW     = 7,
   parameter int PROG_CYCLES = PROG_MIN_CYC
)
(
   input  wire logic               mclk,
   input  wire logic               reset_n,
   input  wire logic               clk_en,
   input  wire logic [7:0]         io_addr,
   input  wire logic               io_is_port,
   input  wire logic               io_wr,
   input  wire logic               io_rd,
   input  wire logic [7:0]         io_wdata,
   output      logic [7:0]         io_rdata_q,
   input  wire logic               spm_exec,
   input  wire logic               lpm_exec,
   input  wire logic [15:0]        z_ptr,
   input  wire logic [15:0]        r1r0,
   input  wire logic               global_irq_en,
   input  wire logic               eeprom_write_active,
   input  wire logic [7:0]         lock_bits,
   input  wire logic [7:0]         fuse_low,
   input  wire logic [7:0]         fuse_high,
   input  wire logic [7:0]         fuse_ext,
   input  wire logic [7:0]         signature_byte,
   output      logic               lpm_override_q,
   output      logic [7:0]         lpm_data_q,
   output      logic               cpu_halt_q,
   output      logic               ready_irq_q,
   output      logic               flash_erase_q,
   output      logic               flash_wr_q,
   output      logic [PAGE_AW-1:0] flash_page_q,
   output      logic [WORD_AW-1:0] flash_word_q,
   output      logic [15:0]        flash_wdata_q
);
   localparam int PAGE_WORDS = 1 << WORD_AW;
   localparam logic [WORD_AW-1:0] LAST_WORD = WORD_AW'(PAGE_WORDS - 1);
   localparam logic [15:0] PROG_LOAD = 16'(PROG_CYCLES - 1);
   page_buf_if #(.AW(WORD_AW), .DW(16)) buf_bus ();
   page_buffer #(.AW(WORD_AW)) u_buf
   (
      .mclk    (mclk),
      .reset_n (reset_n),
      .clk_en  (clk_en),
      .bus     (buf_bus)
   );
   flash_state_t       state_q;
   logic               ie_q;
   logic               arm_q;
   logic               sig_q;
   logic               rww_q;
   logic               blb_q;
   logic               pgw_q;
   logic               pge_q;
   logic [2:0]         win_q;
   logic [15:0]        timer_q;
   logic [WORD_AW-1:0] idx_q;
   logic               stream_q;
   logic               vld1_q;
   logic [WORD_AW-1:0] word1_q;
   logic               wr_hit;
   logic               rd_hit;
   logic [4:0]         cmd;
   logic               legal;
   logic               arm_wr;
   logic               idle;
   logic               spm_take;
   logic               lpm_take;
   logic               done;
   logic               expire;
   logic [7:0]         ctrl_value;

   function automatic logic ctrl_hit(input logic [7:0] addr, input logic port);
      ctrl_hit = port ? (addr == CTRL_DATA_OFFSET - PORT_SHIFT)
                      : (addr == CTRL_DATA_OFFSET);
   endfunction

   assign idle   = (state_q == ST_IDLE);
   assign wr_hit = io_wr && ctrl_hit(io_addr, io_is_port);
   assign rd_hit = io_rd && ctrl_hit(io_addr, io_is_port);
   assign cmd    = io_wdata[4:0];
   // signature read is only legal on top of the plain arm pattern
   assign legal  = (cmd == CMD_ERASE || cmd == CMD_WRITE || cmd == CMD_LOCK ||
                    cmd == CMD_REEN || cmd == CMD_FILL) &&
                   !(io_wdata[BIT_SIG] && cmd != CMD_FILL);
   assign arm_wr = wr_hit && legal && idle && !eeprom_write_active;
   assign spm_take = spm_exec && arm_q && win_q != 3'h0 && idle &&
                     !eeprom_write_active;
   assign lpm_take = lpm_exec && arm_q && (blb_q || sig_q) &&
                     win_q > ARM_SPM_CYCLES - ARM_LPM_CYCLES &&
                     !eeprom_write_active;
   assign done   = !idle && timer_q == 16'h0000;
   assign expire = idle && arm_q && win_q == 3'h1 && !spm_take && !lpm_take;
   assign ctrl_value = {ie_q, 1'b0, sig_q, rww_q, blb_q, pgw_q, pge_q, arm_q};

   // buffer ports
   assign buf_bus.wr_en   = clk_en && spm_take && !sig_q && !pgw_q && !pge_q &&
                            !rww_q && !blb_q;
   assign buf_bus.wr_addr = z_ptr[WORD_AW:1];
   assign buf_bus.wr_data = r1r0;
   assign buf_bus.clear   = clk_en && ((arm_wr && cmd == CMD_REEN) ||
                            (done && state_q == ST_WRITE));
   assign buf_bus.rd_addr = idx_q;

   always_ff @(posedge mclk)
   begin
      if (!reset_n)
         ie_q <= CTRL_RESET[BIT_IE];
      else if (clk_en && wr_hit)
         ie_q <= io_wdata[BIT_IE];
   end

   // command bits and arm window
   always_ff @(posedge mclk)
   begin
      if (!reset_n)
      begin
         arm_q <= CTRL_RESET[BIT_ARM];
         sig_q <= CTRL_RESET[BIT_SIG];
         rww_q <= CTRL_RESET[BIT_RWW];
         blb_q <= CTRL_RESET[BIT_BLB];
         pgw_q <= CTRL_RESET[BIT_PGW];
         pge_q <= CTRL_RESET[BIT_PGE];
         win_q <= 3'h0;
      end
      else if (clk_en)
      begin
         if (arm_wr)
         begin
            arm_q <= 1'b1;
            sig_q <= io_wdata[BIT_SIG];
            rww_q <= io_wdata[BIT_RWW];
            blb_q <= io_wdata[BIT_BLB];
            pgw_q <= io_wdata[BIT_PGW];
            pge_q <= io_wdata[BIT_PGE];
            win_q <= ARM_SPM_CYCLES;
         end
         else if (done)
         begin
            arm_q <= 1'b0;
            pgw_q <= 1'b0;
            pge_q <= 1'b0;
         end
         else if (expire || lpm_take ||
                  (spm_take && !sig_q && !pgw_q && !pge_q))
         begin
            arm_q <= 1'b0;
            sig_q <= 1'b0;
            rww_q <= 1'b0;
            blb_q <= 1'b0;
            pgw_q <= 1'b0;
            pge_q <= 1'b0;
            win_q <= 3'h0;
         end
         else if (spm_take && (pgw_q || pge_q))
            win_q <= 3'h0;
         else if (idle && win_q != 3'h0)
            win_q <= win_q - 3'h1;
      end
   end

   // erase and write sequencing
   always_ff @(posedge mclk)
   begin
      if (!reset_n)
      begin
         state_q       <= ST_IDLE;
         timer_q       <= 16'h0000;
         cpu_halt_q    <= 1'b0;
         flash_erase_q <= 1'b0;
         flash_page_q  <= '0;
      end
      else if (clk_en)
      begin
         flash_erase_q <= 1'b0;
         unique case (state_q)
            ST_IDLE:
            begin
               // signature arming blocks both actions here
               if (spm_take && !sig_q && (pge_q || pgw_q))
               begin
                  state_q       <= pge_q ? ST_ERASE : ST_WRITE;
                  timer_q       <= PROG_LOAD;
                  cpu_halt_q    <= 1'b1;
                  flash_erase_q <= pge_q;
                  flash_page_q  <= z_ptr[WORD_AW+PAGE_AW:WORD_AW+1];
               end
            end
            ST_ERASE, ST_WRITE:
            begin
               if (done)
               begin
                  state_q    <= ST_IDLE;
                  cpu_halt_q <= 1'b0;
               end
               else
                  timer_q <= timer_q - 16'h0001;
            end
         endcase
      end
   end

   // buffer to flash copy, two register stages deep
   always_ff @(posedge mclk)
   begin
      if (!reset_n)
      begin
         idx_q         <= '0;
         stream_q      <= 1'b0;
         vld1_q        <= 1'b0;
         word1_q       <= '0;
         flash_wr_q    <= 1'b0;
         flash_word_q  <= '0;
         flash_wdata_q <= ERASED_WORD;
      end
      else if (clk_en)
      begin
         if (idle && spm_take && !sig_q && pgw_q && !pge_q)
         begin
            stream_q <= 1'b1;
            idx_q    <= '0;
         end
         else if (stream_q)
         begin
            idx_q <= idx_q + 1'b1;
            if (idx_q == LAST_WORD)
               stream_q <= 1'b0;
         end
         vld1_q        <= stream_q;
         word1_q       <= idx_q;
         flash_wr_q    <= vld1_q;
         flash_word_q  <= word1_q;
         flash_wdata_q <= buf_bus.rd_data;
      end
   end

   // special load results
   always_ff @(posedge mclk)
   begin
      if (!reset_n)
      begin
         lpm_override_q <= 1'b0;
         lpm_data_q     <= 8'h00;
      end
      else if (clk_en)
      begin
         lpm_override_q <= lpm_take;
         if (lpm_take && sig_q)
            lpm_data_q <= signature_byte;
         else if (lpm_take)
         begin
            unique case (z_ptr[1:0])
               Z_LOCK[1:0]:      lpm_data_q <= lock_bits;
               Z_FUSE_EXT[1:0]:  lpm_data_q <= fuse_ext;
               Z_FUSE_HIGH[1:0]: lpm_data_q <= fuse_high;
               Z_FUSE_LOW[1:0]:  lpm_data_q <= fuse_low;
            endcase
         end
      end
   end

   always_ff @(posedge mclk)
   begin
      if (!reset_n)
      begin
         io_rdata_q  <= 8'h00;
         ready_irq_q <= 1'b0;
      end
      else if (clk_en)
      begin
         io_rdata_q  <= rd_hit ? ctrl_value : 8'h00;
         ready_irq_q <= ie_q && global_irq_en && !arm_q && idle &&
                        !eeprom_write_active;
      end
   end
   a_busy_bit_zero: assert property (@(posedge mclk) disable iff (!reset_n)
      io_rdata_q[BIT_BUSY] == 1'b0) else $error("busy bit read as one");
   a_port_alias: assert property (@(posedge mclk) disable iff (!reset_n)
      (clk_en && io_rd && io_is_port && io_addr == CTRL_DATA_OFFSET - PORT_SHIFT)
      |=> io_rdata_q == $past(ctrl_value)) else $error("port read wrong");
   a_irq_held: assert property (@(posedge mclk) disable iff (!reset_n)
      (clk_en && ie_q && global_irq_en && !arm_q && idle && !eeprom_write_active)
      |=> ready_irq_q) else $error("ready interrupt missing");
   a_irq_quiet: assert property (@(posedge mclk) disable iff (!reset_n)
      (clk_en && (eeprom_write_active || !idle)) |=> !ready_irq_q)
      else $error("interrupt during busy");
   a_halt_span: assert property (@(posedge mclk) disable iff (!reset_n)
      $rose(cpu_halt_q) |-> cpu_halt_q[*8]) else $error("halt dropped early");
   a_erase_start: assert property (@(posedge mclk) disable iff (!reset_n)
      (clk_en && idle && spm_take && pge_q && !sig_q)
      |=> flash_erase_q && cpu_halt_q && arm_q) else $error("erase not started");
   a_sig_no_store: assert property (@(posedge mclk) disable iff (!reset_n)
      (clk_en && spm_take && sig_q) |=> !cpu_halt_q && !flash_erase_q)
      else $error("store acted on signature");
   a_done_clears: assert property (@(posedge mclk) disable iff (!reset_n)
      (clk_en && done) |=> !arm_q && !pgw_q && !pge_q && !cpu_halt_q)
      else $error("bits not cleared at end");
   a_bad_cmd: assert property (@(posedge mclk) disable iff (!reset_n)
      (clk_en && wr_hit && !legal && !arm_q) |=> !arm_q)
      else $error("illegal pattern armed");
   a_window_len: assert property (@(posedge mclk) disable iff (!reset_n)
      (clk_en && arm_wr && cmd == CMD_FILL && !io_wdata[BIT_SIG]) ##1
      (clk_en && !spm_exec && !wr_hit)[*4] |=> !arm_q)
      else $error("arm window not four cycles");
endmodule

// ===== spm_pkg.sv
// Purpose: shared constants for the self-programming control block
// Assumes: 10 MHz mclk
// Notes:   one-hot flash state codes
package spm_pkg;
   localparam logic [7:0]  CTRL_DATA_OFFSET = 8'h57;
   localparam logic [7:0]  PORT_SHIFT       = 8'h20;
   localparam logic [7:0]  CTRL_RESET       = 8'h00;
   localparam int          BIT_IE           = 7;
   localparam int          BIT_BUSY         = 6;
   localparam int          BIT_SIG          = 5;
   localparam int          BIT_RWW          = 4;
   localparam int          BIT_BLB          = 3;
   localparam int          BIT_PGW          = 2;
   localparam int          BIT_PGE          = 1;
   localparam int          BIT_ARM          = 0;
   localparam logic [4:0]  CMD_FILL         = 5'h01;
   localparam logic [4:0]  CMD_ERASE        = 5'h03;
   localparam logic [4:0]  CMD_WRITE        = 5'h05;
   localparam logic [4:0]  CMD_LOCK         = 5'h09;
   localparam logic [4:0]  CMD_REEN         = 5'h11;
   localparam logic [15:0] Z_FUSE_LOW       = 16'h0000;
   localparam logic [15:0] Z_LOCK           = 16'h0001;
   localparam logic [15:0] Z_FUSE_EXT       = 16'h0002;
   localparam logic [15:0] Z_FUSE_HIGH      = 16'h0003;
   localparam logic [2:0]  ARM_SPM_CYCLES   = 3'h4;
   localparam logic [2:0]  ARM_LPM_CYCLES   = 3'h3;
   localparam logic [15:0] ERASED_WORD      = 16'hFFFF;
   localparam int          CLK_NS           = 100;
   localparam int          PROG_MIN_NS      = 3200000;
   localparam int          PROG_MAX_NS      = 3400000;
   localparam int          PROG_MIN_CYC     = (PROG_MIN_NS + CLK_NS - 1) / CLK_NS;
   localparam int          PROG_MAX_CYC     = PROG_MAX_NS / CLK_NS;
   typedef enum logic [2:0]
   {
      ST_IDLE  = 3'b001,
      ST_ERASE = 3'b010,
      ST_WRITE = 3'b100
   } flash_state_t;
endpackage

// ===== page_buf_if.sv
// Purpose: carrier between control logic and the temporary page buffer
// Assumes: read data one cycle after address
// Notes:   clear empties every word at once
`timescale 1ns/1ns
interface page_buf_if #(parameter int AW = 5, parameter int DW = 16);
   logic          wr_en;
   logic [AW-1:0] wr_addr;
   logic [DW-1:0] wr_data;
   logic          clear;
   logic [AW-1:0] rd_addr;
   logic [DW-1:0] rd_data;
   modport ctrl (output wr_en, wr_addr, wr_data, clear, rd_addr, input rd_data);
   modport mem  (input wr_en, wr_addr, wr_data, clear, rd_addr, output rd_data);
endinterface

// ===== page_buffer.sv
// Purpose: temporary page buffer with per-word valid flags
// Assumes: synchronous active-low reset
// Notes:   cleared words read as erased flash
`timescale 1ns/1ns
module page_buffer
   import spm_pkg::*;
#(
   parameter int AW = 5
)
(
   input  wire logic mclk,
   input  wire logic reset_n,
   input  wire logic clk_en,
   page_buf_if.mem   bus
);
   logic [15:0]        mem_q [0:(1<<AW)-1];
   logic [(1<<AW)-1:0] valid_q;
   logic [15:0]        rd_q;

   // valid flags make a whole-page clear a single cycle
   always_ff @(posedge mclk)
   begin
      if (!reset_n)
         valid_q <= '0;
      else if (clk_en)
      begin
         // a word stored in the clearing cycle survives: set wins
         if (bus.clear)
            valid_q <= '0;
         if (bus.wr_en)
            valid_q[bus.wr_addr] <= 1'b1;
      end
   end

   always_ff @(posedge mclk)
   begin
      if (clk_en && bus.wr_en)
         mem_q[bus.wr_addr] <= bus.wr_data;
   end

   always_ff @(posedge mclk)
   begin
      if (!reset_n)
         rd_q <= ERASED_WORD;
      else if (clk_en)
         rd_q <= valid_q[bus.rd_addr] ? mem_q[bus.rd_addr] : ERASED_WORD;
   end

   assign bus.rd_data = rd_q;
endmodule

// ===== cpu_model.sv
// Purpose: cpu core model issuing register, store and load accesses
// Assumes: drives on falling mclk, one access at a time
// Notes:   cmd polls nothing while halted, but wr and rd ignore halt; released data lines show inverted values
`timescale 1ns/1ns
module cpu_model
(
   input  wire logic        mclk,
   input  wire logic [7:0]  io_rdata_q,
   input  wire logic        cpu_halt_q,
   input  wire logic        eeprom_write_active,
   output      logic [7:0]  io_addr,
   output      logic        io_is_port,
   output      logic        io_wr,
   output      logic        io_rd,
   output      logic [7:0]  io_wdata,
   output      logic        spm_exec,
   output      logic        lpm_exec,
   output      logic [15:0] z_ptr,
   output      logic [15:0] r1r0,
   output      logic        global_irq_en
);
   int spm_delay = 0;
   bit timed_out = 1'b0;

   initial
   begin
      io_addr       = 8'h00;
      io_is_port    = 1'b0;
      io_wr         = 1'b0;
      io_rd         = 1'b0;
      io_wdata      = 8'h00;
      spm_exec      = 1'b0;
      lpm_exec      = 1'b0;
      z_ptr         = 16'h0000;
      r1r0          = 16'h0000;
      global_irq_en = 1'b1;
   end

   task automatic wr(input logic [7:0] a, input logic p, input logic [7:0] d);
      @(negedge mclk);
      io_addr    = a;
      io_is_port = p;
      io_wdata   = d;
      io_wr      = 1'b1;
      @(negedge mclk);
      io_wr      = 1'b0;
      io_wdata   = ~d;
   endtask

   task automatic rd(input logic [7:0] a, input logic p, output logic [7:0] d);
      @(negedge mclk);
      io_addr    = a;
      io_is_port = p;
      io_rd      = 1'b1;
      @(negedge mclk);
      io_rd      = 1'b0;
      d          = io_rdata_q;
   endtask

   // raw skips the polite preamble so a scenario can break it
   task automatic cmd(input logic [7:0] c, input logic [15:0] z, input logic [15:0] d,
                      input logic use_lpm, input logic raw);
      logic [7:0] s;
      logic       gie;
      s = 8'h01;
      for (int i = 0; i < 400 && !raw && (s & 8'h41) !== 8'h00; i++)
         if (cpu_halt_q !== 1'b0)
            @(negedge mclk);
         else
            rd(8'h37, 1'b1, s);
      timed_out = timed_out | (!raw && (s & 8'h41) !== 8'h00);
      gie = global_irq_en;
      global_irq_en = 1'b0;
      for (int i = 0; i < 400 && !raw && eeprom_write_active; i++)
         @(negedge mclk);
      z_ptr = z;
      r1r0  = d;
      wr(8'h37, 1'b1, c);
      repeat (spm_delay) @(negedge mclk);
      if (use_lpm)
         lpm_exec = 1'b1;
      else
         spm_exec = 1'b1;
      @(negedge mclk);
      spm_exec      = 1'b0;
      lpm_exec      = 1'b0;
      global_irq_en = gie;
      z_ptr         = ~z;
      r1r0          = ~d;
   endtask
endmodule

// ===== test_self_program_control.sv
// Purpose: self-checking bench for the self-programming control block
// Assumes: shortened programming time parameter
// Notes:   flash side observed at the outputs only
`timescale 1ns/1ns
module test_self_program_control
   import spm_pkg::*;
;
   localparam int PC = 64;
   typedef struct packed {logic p; logic [7:0] a; logic [7:0] d; logic [7:0] e;} row_t;
   logic        mclk, reset_n, eeprom_write_active, io_is_port, io_wr, io_rd;
   logic        spm_exec, lpm_exec, global_irq_en, lpm_override_q, cpu_halt_q, clk_en;
   logic        ready_irq_q, flash_erase_q, flash_wr_q;
   logic [7:0]  io_addr, io_wdata, io_rdata_q, lpm_data_q, fb, rv;
   logic [15:0] z_ptr, r1r0, flash_wdata_q;
   logic [6:0]  flash_page_q, pg;
   logic [4:0]  flash_word_q;
   logic [15:0] wdat [32];
   logic [7:0]  cm [3] = '{8'h05, 8'h03, 8'h01};
   logic [7:0]  xm [4] = '{8'h11, 8'h00, 8'h33, 8'h22};
   int          bad_count = 0;
   int          tests_run = 0;
   int          wr_n, er_n, halt_n;
   row_t        rows [11] = '{'{1'b0, 8'h57, 8'h80, 8'h80}, '{1'b1, 8'h37, 8'h81, 8'h81},
      '{1'b0, 8'h57, 8'h41, 8'h01}, '{1'b0, 8'h57, 8'h07, 8'h00}, '{1'b0, 8'h57, 8'h0D, 8'h00},
      '{1'b0, 8'h57, 8'h02, 8'h00}, '{1'b0, 8'h57, 8'h21, 8'h21}, '{1'b0, 8'h57, 8'h09, 8'h09},
      '{1'b0, 8'h57, 8'h03, 8'h03}, '{1'b1, 8'h57, 8'h80, 8'h00}, '{1'b0, 8'h58, 8'h80, 8'h00}};

   self_program_control #(.PROG_CYCLES(PC)) uut
   (
      .mclk(mclk), .reset_n(reset_n), .clk_en(clk_en), .io_addr(io_addr),
      .io_is_port(io_is_port), .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata),
      .io_rdata_q(io_rdata_q), .spm_exec(spm_exec), .lpm_exec(lpm_exec), .z_ptr(z_ptr),
      .r1r0(r1r0), .global_irq_en(global_irq_en), .eeprom_write_active(eeprom_write_active),
      .lock_bits(fb), .fuse_low(fb ^ 8'h11), .fuse_high(fb ^ 8'h22), .fuse_ext(fb ^ 8'h33),
      .signature_byte(fb ^ 8'h44), .lpm_override_q(lpm_override_q), .lpm_data_q(lpm_data_q),
      .cpu_halt_q(cpu_halt_q), .ready_irq_q(ready_irq_q), .flash_erase_q(flash_erase_q),
      .flash_wr_q(flash_wr_q), .flash_page_q(flash_page_q), .flash_word_q(flash_word_q),
      .flash_wdata_q(flash_wdata_q)
   );

   cpu_model cpu
   (
      .mclk(mclk), .io_rdata_q(io_rdata_q), .cpu_halt_q(cpu_halt_q),
      .eeprom_write_active(eeprom_write_active), .io_addr(io_addr), .io_is_port(io_is_port),
      .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata), .spm_exec(spm_exec),
      .lpm_exec(lpm_exec), .z_ptr(z_ptr), .r1r0(r1r0), .global_irq_en(global_irq_en)
   );

   // posedge sampling sees each registered pulse before it moves on
   always @(posedge mclk)
   begin
      if (flash_wr_q === 1'b1)
      begin
         wdat[flash_word_q] = flash_wdata_q;
         wr_n++;
         pg = flash_page_q;
      end
      if (flash_erase_q === 1'b1)
      begin
         er_n++;
         pg = flash_page_q;
      end
      halt_n += (cpu_halt_q === 1'b1);
   end

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   task automatic wait_idle();
      for (int i = 0; i < 4 * PC && cpu_halt_q !== 1'b0; i++)
         @(negedge mclk);
      check(cpu_halt_q, 1'b0);
   endtask

   task automatic page_wr(input logic [6:0] p, input logic full);
      wr_n   = 0;
      halt_n = 0;
      cpu.cmd(8'h85, {3'h0, p, 6'h00}, 16'h0000, 1'b0, 1'b0);
      check(cpu_halt_q, 1'b1);
      // unmasked again by now, so only the busy state and the still-set arm bit hold it off
      repeat (2) @(negedge mclk);
      check(ready_irq_q, 1'b0);
      wait_idle();
      check(16'(wr_n), 16'd32);
      check(pg, p);
      check(halt_n >= PC - 1 && halt_n <= PC + 1, 1'b1);
      for (int k = 0; k < 32; k++)
         check(wdat[k], full ? 16'hC3A0 + 16'(k) : ERASED_WORD);
      cpu.rd(8'h57, 1'b0, rv);
      check(rv, 8'h80);
      check(ready_irq_q, 1'b1);
   endtask

   // last word uses the final cycle of the window
   task automatic fill(input int n);
      for (int k = 0; k < n; k++)
      begin
         cpu.spm_delay = (k == 31) ? 3 : 0;
         cpu.cmd(8'h01, {3'h0, 7'h0A, k[4:0], 1'b1}, 16'hC3A0 + 16'(k), 1'b0, 1'b0);
      end
      cpu.spm_delay = 0;
   endtask

   initial
   begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end

   initial
   begin
      #3000000;
      bad_count++;
      report_and_stop();
   end

   initial
   begin
      reset_n             = 1'b0;
      eeprom_write_active = 1'b0;
      fb                  = 8'h5A;
      clk_en              = 1'b1;
      repeat (2) @(negedge mclk);
      reset_n = 1'b1;
      foreach (rows[i])
      begin
         cpu.wr(rows[i].a, rows[i].p, rows[i].d);
         cpu.rd(rows[i].a, rows[i].p, rv);
         check(rv, rows[i].e);
         repeat (6) @(negedge mclk);
      end
      foreach (cm[i])
      begin
         cpu.wr(8'h37, 1'b1, cm[i]);
         @(negedge mclk);
         cpu.rd(8'h37, 1'b1, rv);
         check(rv, cm[i]);
         cpu.rd(8'h37, 1'b1, rv);
         check(rv, 8'h00);
      end
      // a frozen clock enable must stop the arm window from running out
      cpu.wr(8'h37, 1'b1, 8'h09);
      clk_en = 1'b0;
      repeat (6) @(negedge mclk);
      clk_en = 1'b1;
      cpu.rd(8'h37, 1'b1, rv);
      check(rv, 8'h09);
      for (int j = 0; j < 2; j++)
      begin
         fb = j ? 8'hA5 : 8'h5A;
         for (int z = 0; z < 4; z++)
         begin
            cpu.cmd(8'h09, 16'(z), 16'h0000, 1'b1, 1'b0);
            check(lpm_override_q, 1'b1);
            check(lpm_data_q, fb ^ xm[z]);
         end
      end
      cpu.cmd(8'h21, 16'h0000, 16'h0000, 1'b1, 1'b0);
      check(lpm_override_q, 1'b1);
      check(lpm_data_q, fb ^ 8'h44);
      eeprom_write_active = 1'b1;
      cpu.cmd(8'h09, 16'h0001, 16'h0000, 1'b1, 1'b1);
      check(lpm_override_q, 1'b0);
      cpu.rd(8'h37, 1'b1, rv);
      check(rv, 8'h00);
      eeprom_write_active = 1'b0;
      cpu.wr(8'h37, 1'b1, 8'h80);
      repeat (2) @(negedge mclk);
      check(ready_irq_q, 1'b1);
      eeprom_write_active = 1'b1;
      repeat (2) @(negedge mclk);
      check(ready_irq_q, 1'b0);
      eeprom_write_active = 1'b0;
      cpu.wr(8'h37, 1'b1, 8'h81);
      @(negedge mclk);
      check(ready_irq_q, 1'b0);
      repeat (6) @(negedge mclk);
      cpu.cmd(8'h21, 16'h0002, 16'h1234, 1'b0, 1'b0);
      check(cpu_halt_q, 1'b0);
      page_wr(7'h0A, 1'b0);
      fill(32);
      page_wr(7'h0A, 1'b1);
      page_wr(7'h0B, 1'b0);
      fill(4);
      cpu.cmd(8'h11, 16'h0000, 16'h0000, 1'b0, 1'b0);
      page_wr(7'h0C, 1'b0);
      fill(4);
      reset_n = 1'b0;
      repeat (2) @(negedge mclk);
      reset_n = 1'b1;
      page_wr(7'h0D, 1'b0);
      er_n = 0;
      cpu.cmd(8'h03, {3'h0, 7'h15, 6'h00}, 16'h5555, 1'b0, 1'b0);
      check(cpu_halt_q, 1'b1);
      wait_idle();
      check(16'(er_n), 16'd1);
      check(pg, 7'h15);
      cpu.rd(8'h37, 1'b1, rv);
      check(rv, 8'h00);
      check(cpu.timed_out, 1'b0);
      report_and_stop();
   end
endmodule
